// [dv/acr_host.sv]
/*
 * APB host model standing in for the controller that programs the register bank.
 * Assumes it shares clk_in with the bank and that the bench calls xfer.
 */
module acr_host (
	input  wire logic        clk_in,
	input  wire logic [31:0] prdata_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic      [7:0]  paddr_out,
	output logic      [31:0] pwdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
	end
	// Holds the request until pready is seen high, then releases it.
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= wr;
		paddr_out <= {2'h0, idx, 2'h0};
		pwdata_out <= wd;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// No cycle limit here: only the bench watchdog ends a wait.
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		rd = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		pwdata_out <= ~wd;
	endtask : xfer
endmodule : acr_host

// [dv/tb.sv]
/*
 * Self-checking bench for the converter register bank.
 * Assumes the host model drives APB and the bench drives the load fail pin.
 */
module tb
	import acr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        fail_pin = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic        boost, reference_source_select, pdown, lane, flagen, flush, sdone, irq;
	logic [2:0]  shift;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors = 0;
	int          n_tests = 0;
	int          n_flush = 0;
	int          f0;
	wire  [7:0]  outs = {boost, reference_source_select, pdown, lane, flagen, shift};
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in) if (flush === 1'b1) n_flush <= n_flush + 1;
	acr_regs acr_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .setup_load_fail_in(fail_pin),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .resolution_boost_out(boost),
		.reference_source_select_out(reference_source_select), .power_down_select_out(pdown), .output_lane_count_out(lane),
		.flag_pin_enable_out(flagen), .oversample_shift_out(shift), .flush_out(flush),
		.setup_done_out(sdone), .irq_out(irq));
	acr_host acr_host_inst (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
		.psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	// Builds a word with the register's own index and a good or bad check byte.
	task automatic rw(input logic wr, input logic [3:0] idx, input logic [11:0] lo, input logic bad = 1'b0);
		logic [7:0] c;
		c = {idx, lo[11:8]} ^ lo[7:0] ^ {7'h0, bad};
		acr_host_inst.xfer(wr, idx, {8'h0, c, idx, lo}, rd, err);
		cyc(2);
	endtask : rw
	task automatic close_out;
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic t_reset;
		cyc(SETUP_CYCLES - 2);
		chk(sdone, 1'b0);
		cyc(4);
		chk(sdone, 1'b1);
		chk(outs, 8'h00);
		for (int i = 1; i < 4; i++) begin
			rw(1'b0, i[3:0], 12'h0);
			chk(rd, {16'h0, i[3:0], 12'h0});
		end
		$display("t_reset done");
	endtask : t_reset
	task automatic t_cfg1;
		logic [2:0] s;
		for (int o = 0; o < 8; o++) begin
			rw(1'b1, 4'h1, {3'h0, o[2:0], 6'h07});
			s = (o >= 1 && o <= 5) ? o[2:0] : 3'h0;
			chk(outs, {s != 3'h0, 4'hC, s});
		end
		rw(1'b1, 4'h1, 12'h0);
		chk(outs, 8'h00);
		$display("t_cfg1 done");
	endtask : t_cfg1
	task automatic t_addr;
		acr_host_inst.xfer(1'b1, 4'h1, 32'h0000_2001, rd, err);
		cyc(2);
		chk({err, pdown}, 2'b10);
		rw(1'b0, 4'h5, 12'h0);
		chk({err, rd}, 33'h1_0000_0000);
		$display("t_addr done");
	endtask : t_addr
	task automatic t_lane;
		rw(1'b1, 4'h1, 12'h008);
		rw(1'b1, 4'h2, 12'h100);
		chk({lane, flagen}, 2'b11);
		rw(1'b0, 4'h2, 12'h0);
		chk(rd, 32'h2100);
		rw(1'b1, 4'h2, 12'h000);
		chk({lane, flagen}, 2'b00);
		rw(1'b1, 4'h1, 12'h000);
		$display("t_lane done");
	endtask : t_lane
	task automatic t_wcheck;
		rw(1'b1, 4'h7, 12'h003);
		rw(1'b1, 4'h1, 12'h020);
		rw(1'b1, 4'h1, 12'h021, 1'b1);
		chk({err, pdown, irq}, 3'b001);
		rw(1'b1, 4'h3, 12'h000);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3200);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3000);
		rw(1'b1, 4'h6, 12'h001);
		chk(irq, 1'b0);
		$display("t_wcheck done");
	endtask : t_wcheck
	task automatic t_resets;
		rw(1'b1, 4'h1, 12'h022);
		rw(1'b1, 4'h1, 12'h000, 1'b1);
		f0 = n_flush;
		rw(1'b1, 4'h2, 12'h05A);
		chk({n_flush - f0, reference_source_select}, 33'h1);
		rw(1'b1, 4'h2, 12'h03C);
		chk({n_flush - f0, reference_source_select}, 33'h3);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3000);
		rw(1'b0, 4'h1, 12'h0);
		chk(rd, 32'h1022);
		rw(1'b1, 4'h2, 12'h0FF);
		chk({n_flush - f0, outs}, 40'h2_00);
		rw(1'b0, 4'h7, 12'h0);
		chk(rd, 32'h7000);
		cyc(SETUP_CYCLES + 4);
		$display("t_resets done");
	endtask : t_resets
	task automatic t_setup;
		fail_pin <= 1'b1;
		rw(1'b1, 4'h2, 12'h0FF);
		cyc(SETUP_CYCLES + 4);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3100);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3100);
		fail_pin <= 1'b0;
		rw(1'b1, 4'h2, 12'h0FF);
		cyc(SETUP_CYCLES + 4);
		rw(1'b0, 4'h3, 12'h0);
		chk(rd, 32'h3000);
		$display("t_setup done");
	endtask : t_setup
	initial begin
		cyc(5);
		rst_n_in <= 1'b1;
		t_reset();
		t_cfg1();
		t_addr();
		t_lane();
		t_wcheck();
		t_resets();
		t_setup();
		close_out();
	end
	initial begin
		cyc(20000);
		num_errors++;
		close_out();
	end
endmodule : tb

// [src/acr_pkg.sv]
/*
 * Shared constants for the converter configuration and fault register bank.
 * Assumes a single 20 MHz clock and an APB master with 32-bit data.
 */
package acr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SETUP_TIME_NS = 1000;
	localparam int unsigned SETUP_CYCLES  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETUP_CNT_W   = 5;

	localparam logic [3:0] CFG1_IDX  = 4'h1;
	localparam logic [3:0] CFG2_IDX  = 4'h2;
	localparam logic [3:0] FAULT_IDX = 4'h3;
	localparam logic [3:0] STAT_IDX  = 4'h6;
	localparam logic [3:0] MASK_IDX  = 4'h7;

	localparam int unsigned ADDR_HI  = 15;
	localparam int unsigned ADDR_LO  = 12;
	localparam int unsigned OSR_HI   = 8;
	localparam int unsigned OSR_LO   = 6;
	localparam int unsigned WCE_BIT  = 5;
	localparam int unsigned FLAG_BIT = 3;
	localparam int unsigned RES_BIT  = 2;
	localparam int unsigned REF_BIT  = 1;
	localparam int unsigned PM_BIT   = 0;
	localparam int unsigned LANE_BIT = 8;
	localparam int unsigned WCF_BIT  = 9;
	localparam int unsigned SUF_BIT  = 8;
	localparam int unsigned CHK_HI   = 23;
	localparam int unsigned CHK_LO   = 16;

	localparam logic [7:0]  SOFT_RESET_CODE = 8'h3C;
	localparam logic [7:0]  HARD_RESET_CODE = 8'hFF;
	localparam logic [2:0]  OSR_OFF         = 3'h0;
	localparam logic [2:0]  OSR_MAX         = 3'h5;
	localparam logic [2:0]  CFG1_OSR_RST    = 3'h0;
	localparam logic [1:0]  IRQ_RST         = 2'h0;

	typedef enum logic [0:0] {
		ACR_SETUP,
		ACR_RUN
	} acr_st_t;
endpackage : acr_pkg

// [src/acr_regs.sv]
/*
 * Configuration and fault register bank of a dual SAR converter, reached over APB.
 * It holds both configuration words, the fault flags and an interrupt status and mask pair.
 * Assumes a synchronous APB master on clk_in and an asynchronous setup load fail pin.
 * Assumes the converter core reads the effective outputs, not the raw register bits.
 */
// Operation
// - Boost adds two bits only when oversampling on.
// - Reference bit selects internal or external.
// - Power bit selects normal or shutdown.
// - Word top four bits carry register address.
// - Lane bit selects both outputs or first.
// - Code 3C clears write check flag, flushes, keeps registers.
// - Code FF restores every register default.
// - Other reset codes do nothing.
// - Bad checksum write sets sticky flag, read clears.
// - Setup load failure sets setup flag.
// - Setup flag cleared only by hard reset.
// - Ratio codes 1..5 active, others disabled.
// - Flag pin enable only in single lane.
module acr_regs
	import acr_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic        setup_load_fail_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             resolution_boost_out,
	output logic             reference_source_select_out,
	output logic             power_down_select_out,
	output logic             output_lane_count_out,
	output logic             flag_pin_enable_out,
	output logic      [2:0]  oversample_shift_out,
	output logic             flush_out,
	output logic             setup_done_out,
	output logic             irq_out
);
	typedef struct packed {
		acr_st_t                st;
		logic [SETUP_CNT_W-1:0] cnt;
		logic                   fail_s1;
		logic                   fail_s2;
		logic [2:0]             oversample_ratio;
		logic                   wce;
		logic                   flag_en;
		logic                   res;
		logic                   reference_source_select;
		logic                   power_down_select;
		logic                   lane;
		logic                   wcf;
		logic                   suf;
		logic [1:0]             stat;
		logic [1:0]             mask;
		logic                   pready;
		logic                   pslverr;
		logic [15:0]            prdata;
		logic                   res_eff;
		logic                   flag_eff;
		logic [2:0]             osr_shift;
		logic                   flush;
		logic                   irq;
		logic                   done;
	} acr_state_t;

	localparam logic [SETUP_CNT_W-1:0] SETUP_LAST = SETUP_CNT_W'(SETUP_CYCLES - 1);

	acr_state_t q;
	acr_state_t n;

	logic [3:0] idx;
	logic       hit;
	logic       acc;
	logic       commit;
	logic       addr_ok;
	logic       chk_ok;
	logic       wr_go;
	logic       setup_ev;
	logic       good_wr;
	logic       cfg1_wr;
	logic       cfg2_wr;
	logic       hard_wr;
	logic       soft_wr;
	logic       fault_rd;
	logic [2:0] wr_osr;

	assign idx     = paddr_in[5:2];
	assign hit     = (paddr_in[7:6] == 2'h0) && (paddr_in[1:0] == 2'h0) &&
	                 (idx == CFG1_IDX || idx == CFG2_IDX || idx == FAULT_IDX ||
	                  idx == STAT_IDX || idx == MASK_IDX);
	assign acc     = psel_in && penable_in && !q.pready;
	assign commit  = psel_in && penable_in && q.pready;
	assign addr_ok = pwdata_in[ADDR_HI:ADDR_LO] == idx;
	assign chk_ok  = !q.wce || (pwdata_in[CHK_HI:CHK_LO] == (pwdata_in[15:8] ^ pwdata_in[7:0]));
	assign wr_go   = commit && pwrite_in && hit && addr_ok;
	assign setup_ev = (q.st == ACR_SETUP) && (q.cnt == SETUP_LAST) && q.fail_s2;

	// Decoded bus events for the checks below; only fault_rd also feeds the read clear.
	assign good_wr  = wr_go && chk_ok;
	assign cfg1_wr  = good_wr && idx == CFG1_IDX;
	assign cfg2_wr  = good_wr && idx == CFG2_IDX;
	assign hard_wr  = cfg2_wr && pwdata_in[7:0] == HARD_RESET_CODE;
	assign soft_wr  = cfg2_wr && pwdata_in[7:0] == SOFT_RESET_CODE;
	assign fault_rd = commit && !pwrite_in && hit && idx == FAULT_IDX;
	assign wr_osr   = pwdata_in[OSR_HI:OSR_LO];

	always_comb begin
		logic hard;
		hard      = 1'b0;
		n         = q;
		n.fail_s1 = setup_load_fail_in;
		n.fail_s2 = q.fail_s1;
		n.flush   = 1'b0;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;

		// Answer is prepared one cycle into the access phase, committed when pready is seen.
		if (acc) begin
			n.pready  = 1'b1;
			n.pslverr = !hit || (pwrite_in && !addr_ok);
			n.prdata  = 16'h0000;
			if (hit) begin
				unique case (idx)
					CFG1_IDX:  n.prdata = {CFG1_IDX, 3'h0, q.oversample_ratio, q.wce, 1'b0, q.flag_en, q.res, q.reference_source_select, q.power_down_select};
					CFG2_IDX:  n.prdata = {CFG2_IDX, 3'h0, q.lane, 8'h00};
					FAULT_IDX: n.prdata = {FAULT_IDX, 2'h0, q.wcf, q.suf, 8'h00};
					STAT_IDX:  n.prdata = {STAT_IDX, 10'h000, q.stat};
					MASK_IDX:  n.prdata = {MASK_IDX, 10'h000, q.mask};
					default:   n.prdata = 16'h0000;
				endcase
			end
		end

		// Only the flag value that was actually returned is cleared by the read.
		if (fault_rd) begin
			n.wcf = q.wcf && !q.prdata[WCF_BIT];
		end

		if (wr_go) begin
			if (!chk_ok) begin
				n.wcf     = 1'b1;
				n.stat[0] = 1'b1;
			end else begin
				unique case (idx)
					CFG1_IDX: begin
						n.oversample_ratio     = pwdata_in[OSR_HI:OSR_LO];
						n.wce     = pwdata_in[WCE_BIT];
						n.flag_en = pwdata_in[FLAG_BIT];
						n.res     = pwdata_in[RES_BIT];
						n.reference_source_select  = pwdata_in[REF_BIT];
						n.power_down_select   = pwdata_in[PM_BIT];
					end
					CFG2_IDX: begin
						n.lane = pwdata_in[LANE_BIT];
						if (pwdata_in[7:0] == SOFT_RESET_CODE) begin
							n.wcf   = 1'b0;
							n.flush = 1'b1;
							n.st    = ACR_RUN;
							n.cnt   = '0;
						end else if (pwdata_in[7:0] == HARD_RESET_CODE) begin
							hard = 1'b1;
						end
						// Any other code leaves reset logic untouched.
					end
					FAULT_IDX: begin
						n.wcf = n.wcf;
					end
					STAT_IDX: n.stat = q.stat & ~pwdata_in[1:0];
					MASK_IDX: n.mask = pwdata_in[1:0];
					default:  n.stat = n.stat;
				endcase
			end
		end

		if (hard) begin
			n.oversample_ratio     = CFG1_OSR_RST;
			n.wce     = 1'b0;
			n.flag_en = 1'b0;
			n.res     = 1'b0;
			n.reference_source_select  = 1'b0;
			n.power_down_select   = 1'b0;
			n.lane    = 1'b0;
			n.wcf     = 1'b0;
			n.suf     = 1'b0;
			n.stat    = IRQ_RST;
			n.mask    = IRQ_RST;
			n.flush   = 1'b1;
			n.st      = ACR_SETUP;
			n.cnt     = '0;
		end else if (q.st == ACR_SETUP && !n.flush) begin
			// Setup sets are applied last so they win over a same-cycle status write clear; a reset write skips them.
			if (q.cnt == SETUP_LAST) begin
				n.st  = ACR_RUN;
				n.cnt = '0;
				if (setup_ev) begin
					n.suf     = 1'b1;
					n.stat[1] = 1'b1;
				end
			end else begin
				n.cnt = q.cnt + 1'b1;
			end
		end

		n.res_eff   = n.res && (n.oversample_ratio != OSR_OFF) && (n.oversample_ratio <= OSR_MAX);
		n.osr_shift = (n.oversample_ratio <= OSR_MAX) ? n.oversample_ratio : OSR_OFF;
		n.flag_eff  = n.lane && n.flag_en;
		n.irq       = |(n.stat & n.mask);
		// Setup completion gets its own flop so the output carries no decode.
		n.done      = n.st == ACR_RUN;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign prdata_out                  = {16'h0000, q.prdata};
	assign pready_out                  = q.pready;
	assign pslverr_out                 = q.pslverr;
	assign resolution_boost_out        = q.res_eff;
	assign reference_source_select_out = q.reference_source_select;
	assign power_down_select_out       = q.power_down_select;
	assign output_lane_count_out       = q.lane;
	assign flag_pin_enable_out         = q.flag_eff;
	assign oversample_shift_out        = q.osr_shift;
	assign flush_out                   = q.flush;
	assign setup_done_out              = q.done;
	assign irq_out                     = q.irq;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// First configuration word: boost, ratio, reference and power bits.
	AST_RES_OFF: assert property (
		(q.oversample_ratio == OSR_OFF || q.oversample_ratio > OSR_MAX) |->
		!q.res_eff)
		else $error("Boost active while oversampling is off.");
	AST_RES_ON: assert property (
		cfg1_wr && pwdata_in[RES_BIT] && wr_osr == 3'h3 |=>
		resolution_boost_out)
		else $error("Boost not active with ratio eight.");
	AST_SHIFT_ON: assert property (
		cfg1_wr && wr_osr != OSR_OFF && wr_osr <= OSR_MAX |=>
		oversample_shift_out == $past(wr_osr))
		else $error("Active ratio not passed on.");
	AST_SHIFT_OFF: assert property (
		cfg1_wr && (wr_osr == OSR_OFF || wr_osr > OSR_MAX) |=>
		oversample_shift_out == OSR_OFF && !resolution_boost_out)
		else $error("Disabled ratio code still active.");
	AST_REF: assert property (
		cfg1_wr |=>
		reference_source_select_out == $past(pwdata_in[REF_BIT]))
		else $error("Reference select not taken.");
	AST_POWER_DOWN_SELECT: assert property (
		cfg1_wr |=>
		power_down_select_out == $past(pwdata_in[PM_BIT]))
		else $error("Power select not taken.");

	// Bus decoding, refusal and the single wait state.
	AST_ADDR: assert property (
		acc && pwrite_in && hit && !addr_ok |=>
		pslverr_out ##1 $stable(q.oversample_ratio))
		else $error("Mismatched address field accepted.");
	AST_UNMAPPED: assert property (
		acc && !hit |=>
		pslverr_out && prdata_out == 32'h0000_0000)
		else $error("Unmapped access not refused.");
	AST_READY: assert property (
		acc |=>
		pready_out ##1 !pready_out)
		else $error("Ready timing wrong.");

	// Second configuration word, its reset codes and the flag pin enable.
	AST_LANE: assert property (
		cfg2_wr |=>
		output_lane_count_out == $past(pwdata_in[LANE_BIT]))
		else $error("Lane select not taken.");
	AST_SOFT: assert property (
		soft_wr |=>
		flush_out && !q.wcf && $stable(q.reference_source_select) && $stable(q.oversample_ratio))
		else $error("Soft reset misbehaved.");
	AST_HARD: assert property (
		hard_wr |=>
		!q.power_down_select && !q.suf && !q.lane && q.st == ACR_SETUP && q.cnt == '0)
		else $error("Hard reset left state behind.");
	AST_OTHER: assert property (
		cfg2_wr && !soft_wr && !hard_wr |=>
		!flush_out && $stable(q.reference_source_select))
		else $error("Unknown reset code acted.");
	AST_FLAG: assert property (
		!q.lane |->
		!flag_pin_enable_out)
		else $error("Flag pin enabled in two lane mode.");

	// Fault flags: how they are set, how long they hold and what clears them.
	AST_WCF: assert property (
		wr_go && !chk_ok |=>
		q.wcf && q.stat[0] && $stable(q.reference_source_select))
		else $error("Rejected write not flagged.");
	AST_WCF_HOLD: assert property (
		q.wcf && !fault_rd && !soft_wr && !hard_wr |=>
		q.wcf)
		else $error("Write check flag dropped without a read.");
	AST_WCF_CLR: assert property (
		fault_rd && q.prdata[WCF_BIT] |=>
		!q.wcf)
		else $error("Write check flag survived its read.");
	AST_SETUP: assert property (
		setup_ev && !wr_go |=>
		q.suf ##1 q.suf)
		else $error("Setup failure not flagged.");
	AST_SETUP_STAT: assert property (
		setup_ev && !wr_go |=>
		q.stat[1])
		else $error("Setup failure event not recorded.");
	AST_SUF_READ: assert property (
		commit && !pwrite_in && idx == FAULT_IDX && q.suf |=>
		q.suf)
		else $error("Setup flag cleared by read.");
	AST_SUF_HOLD: assert property (
		q.suf && !hard_wr |=>
		q.suf)
		else $error("Setup flag cleared without a hard reset.");
	AST_FAULT_WR: assert property (
		good_wr && idx == FAULT_IDX && q.st == ACR_RUN |=>
		q.wcf == $past(q.wcf) && q.suf == $past(q.suf))
		else $error("Fault register changed by a write.");

	// The setup period ends on its last count unless a hard reset restarts it.
	AST_DONE: assert property (
		q.st == ACR_SETUP && q.cnt == SETUP_LAST && !hard_wr |=>
		setup_done_out)
		else $error("Setup period did not end.");

	// Main scenarios that the bench is expected to reach.
	COV_SOFT:  cover property (soft_wr);
	COV_HARD:  cover property (hard_wr);
	COV_WCF:   cover property ((wr_go && !chk_ok) ##[1:20] fault_rd);
	COV_IRQ:   cover property (irq_out);
	COV_SETUP: cover property (setup_ev);
endmodule : acr_regs
